/* include/pin_state_pkg.sv */
/*
 Shared constants for the low-power pin-state controller: register map, field
 positions, reset values, bus response codes and the processing-mode encoding.
 Assumes an AXI4-Lite master with 32-bit data and an 8-bit byte address.
*/
package pin_state_pkg;
   localparam int ADDR_WIDTH = 8;
   localparam int NUM_PINS_DEF = 16;
   localparam int ANALOG_BITS_DEF = 12;

   // register byte offsets
   localparam logic [7:0] OFS_FUNC_CTRL = 8'h00;
   localparam logic [7:0] OFS_DEEP_CTRL = 8'h04;
   localparam logic [7:0] OFS_SW_WAKE = 8'h08;
   localparam logic [7:0] OFS_DEEP_WAKE = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_ANALOG = 8'h14;

   // function control fields
   localparam int BIT_RTC_SEL = 0;
   localparam int BIT_CLK_SEL = 1;
   localparam int BIT_ANALOG_OE = 2;
   localparam int BIT_USB_INPUT = 3;
   localparam int BIT_USB_DEEP_WAKE = 4;
   localparam int BIT_PULL_EN = 5;
   localparam int FUNC_CTRL_BITS = 6;
   localparam logic [5:0] FUNC_CTRL_RESET = 6'h20;

   // deep standby control and status fields
   localparam int BIT_RETENTION = 0;
   localparam int BIT_SCAN_EN = 4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_RUN,
      MODE_SW_STBY,
      MODE_DEEP_STBY,
      MODE_RETAIN,
      MODE_STARTUP
   } pin_mode_e;
endpackage : pin_state_pkg

/* verilog/pin_state_hold.sv */
/*
 Per-pin state holder for the general pins: follows the live peripheral drive
 while running and freezes or releases it in the low-power modes.
 Assumes the mode input comes from the same clock domain and is registered.
*/
`timescale 1ns/1ps
module pin_state_hold #(
   parameter int NUM_PINS = pin_state_pkg::NUM_PINS_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire pin_state_pkg::pin_mode_e mode,
   input wire logic [NUM_PINS-1:0] liveOut,
   input wire logic [NUM_PINS-1:0] liveOe,
   input wire logic [NUM_PINS-1:0] swWake,
   input wire logic [NUM_PINS-1:0] dsWake,
   output logic [NUM_PINS-1:0] pinOut,
   output logic [NUM_PINS-1:0] pinOe,
   output logic [NUM_PINS-1:0] pinIe
);
   import pin_state_pkg::*;

   // pin registers; outputs never fall through combinationally
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pinOut <= '0;
         pinOe <= '0;
         pinIe <= '0;
      end
      else if (ce)
      begin
         case (mode)
            MODE_RUN:
            begin
               pinOut <= liveOut;
               pinOe <= liveOe;
               pinIe <= ~liveOe;
            end
            MODE_SW_STBY:
            begin
               // drivers keep their level; inputs float unless waking
               pinIe <= swWake & ~pinOe;
            end
            MODE_DEEP_STBY:
            begin
               // wake sources only add input paths, never alter drive
               pinIe <= pinIe | dsWake;
            end
            MODE_RETAIN:
            begin
               pinIe <= pinIe;
            end
            default:
            begin
               pinOe <= '0;
               pinIe <= '0;
            end
         endcase
      end
   end
endmodule : pin_state_hold

/* verilog/low_power_pin_state_control.sv */
/*
 Pin-state controller across run, software standby, deep software standby and
 the return from deep standby, with an AXI4-Lite register slave.
 Assumes standby requests come from the power-mode controller on clk and that
 all peripheral drive inputs are synchronous to clk.
*/
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module low_power_pin_state_control #(
   parameter int NUM_PINS = pin_state_pkg::NUM_PINS_DEF,
   parameter int ANALOG_BITS = pin_state_pkg::ANALOG_BITS_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [pin_state_pkg::ADDR_WIDTH-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [pin_state_pkg::ADDR_WIDTH-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic swStandbyReq,
   input wire logic deepStandbyReq,
   input wire logic [NUM_PINS-1:0] liveOut,
   input wire logic [NUM_PINS-1:0] liveOe,
   output logic [NUM_PINS-1:0] pinOut,
   output logic [NUM_PINS-1:0] pinOe,
   output logic [NUM_PINS-1:0] pinIe,
   input wire logic tdoLive,
   output logic tdoOut,
   output logic tdoOe,
   output logic jtagPullUp,
   output logic bootModePullUp,
   output logic scanEnable,
   input wire logic rtcClkLive,
   output logic rtcOutPin,
   output logic rtcOutOe,
   input wire logic clkOutLive,
   output logic clkOutPin,
   output logic clkOutOe,
   output logic [ANALOG_BITS-1:0] analogOutValue,
   output logic analogOutOe,
   output logic usbDataIe,
   output pin_state_pkg::pin_mode_e pinMode
);
   import pin_state_pkg::*;

   pin_mode_e next_mode;
   logic [FUNC_CTRL_BITS-1:0] funcCtrl;
   logic ioRetention;
   logic [NUM_PINS-1:0] swWake;
   logic [NUM_PINS-1:0] dsWake;
   logic [ANALOG_BITS-1:0] analogData;
   logic [ADDR_WIDTH-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic [31:0] oldWord;
   logic [31:0] mergedWord;
   logic writeFire;
   logic deepCtrlWrite;

   // register image at a byte address; unused bits read zero
   function automatic logic [31:0] regWord(input logic [ADDR_WIDTH-1:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case ({a[ADDR_WIDTH-1:2], 2'b00})
         OFS_FUNC_CTRL: w[FUNC_CTRL_BITS-1:0] = funcCtrl;
         OFS_DEEP_CTRL: w[BIT_RETENTION] = ioRetention;
         OFS_SW_WAKE: w[NUM_PINS-1:0] = swWake;
         OFS_DEEP_WAKE: w[NUM_PINS-1:0] = dsWake;
         OFS_STATUS: w = {27'h0, scanEnable, 1'b0, pinMode};
         OFS_ANALOG: w[ANALOG_BITS-1:0] = analogData;
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction : regWord

   function automatic logic regMapped(input logic [ADDR_WIDTH-1:0] a);
      logic [ADDR_WIDTH-1:0] w;
      w = {a[ADDR_WIDTH-1:2], 2'b00};
      return (w == OFS_FUNC_CTRL) || (w == OFS_DEEP_CTRL) || (w == OFS_SW_WAKE) ||
         (w == OFS_DEEP_WAKE) || (w == OFS_STATUS) || (w == OFS_ANALOG);
   endfunction : regMapped

   // next {oe, out} of a dedicated output pin that may stay live in standby
   function automatic logic [1:0] liveOutNext(input pin_mode_e m, input logic sel,
      input logic live, input logic curOe, input logic curOut);
      logic [1:0] r;
      r = {curOe, curOut};
      case (m)
         MODE_RUN: r = {sel, live};
         MODE_SW_STBY: r = sel ? {1'b1, live} : {curOe, curOut};
         MODE_DEEP_STBY: r = {curOe, curOut};
         MODE_RETAIN: r = {curOe, curOut};
         default: r = {1'b0, curOut};
      endcase
      return r;
   endfunction : liveOutNext

   // both address and data held, response not yet posted
   assign writeFire = !awready && !wready && !bvalid;
   assign deepCtrlWrite = writeFire && ({awAddr[ADDR_WIDTH-1:2], 2'b00} == OFS_DEEP_CTRL);

   // byte-lane merge of the pending write into the current register image
   always_comb
   begin
      oldWord = regWord(awAddr);
      mergedWord = oldWord;
      for (int b = 0; b < 4; b++)
      begin
         if (wStrb[b])
            mergedWord[8*b +: 8] = wData[8*b +: 8];
      end
   end

   // write channels: address and data accepted in either order
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         awAddr <= '0;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            awAddr <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wData <= wdata;
            wStrb <= wstrb;
            wready <= 1'b0;
         end
         if (writeFire)
         begin
            bvalid <= 1'b1;
            bresp <= regMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // read channel: one read in flight, data registered at acceptance
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready)
         begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= regWord(araddr);
            rresp <= regMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // configuration registers; status is read-only and writes to it are dropped
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         funcCtrl <= FUNC_CTRL_RESET;
         ioRetention <= 1'b0;
         swWake <= '0;
         dsWake <= '0;
         analogData <= '0;
      end
      else if (ce && writeFire)
      begin
         case ({awAddr[ADDR_WIDTH-1:2], 2'b00})
            OFS_FUNC_CTRL: funcCtrl <= mergedWord[FUNC_CTRL_BITS-1:0];
            OFS_DEEP_CTRL: ioRetention <= mergedWord[BIT_RETENTION];
            OFS_SW_WAKE: swWake <= mergedWord[NUM_PINS-1:0];
            OFS_DEEP_WAKE: dsWake <= mergedWord[NUM_PINS-1:0];
            OFS_ANALOG: analogData <= mergedWord[ANALOG_BITS-1:0];
            default: ioRetention <= ioRetention;
         endcase
      end
   end

   // processing mode sequencing
   always_comb
   begin
      next_mode = pinMode;
      case (pinMode)
         MODE_RUN:
         begin
            if (deepStandbyReq)
               next_mode = MODE_DEEP_STBY;
            else if (swStandbyReq)
               next_mode = MODE_SW_STBY;
         end
         MODE_SW_STBY:
         begin
            if (deepStandbyReq)
               next_mode = MODE_DEEP_STBY;
            else if (!swStandbyReq)
               next_mode = MODE_RUN;
         end
         MODE_DEEP_STBY:
         begin
            if (!deepStandbyReq)
               next_mode = ioRetention ? MODE_RETAIN : MODE_STARTUP;
         end
         MODE_RETAIN:
         begin
            // pins stay frozen until software drops retention
            if (!ioRetention)
               next_mode = MODE_RUN;
         end
         MODE_STARTUP:
         begin
            if (deepCtrlWrite)
               next_mode = MODE_RUN;
         end
         default: next_mode = MODE_RUN;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         pinMode <= MODE_RUN;
      else if (ce)
         pinMode <= next_mode;
   end

   // scan is held off for the whole reset and enabled after release
   always_ff @(posedge clk)
   begin
      if (srst)
         scanEnable <= 1'b0;
      else if (ce)
         scanEnable <= 1'b1;
   end

   pin_state_hold #(
      .NUM_PINS(NUM_PINS)
   ) u_hold (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .mode(pinMode),
      .liveOut(liveOut),
      .liveOe(liveOe),
      .swWake(swWake),
      .dsWake(dsWake),
      .pinOut(pinOut),
      .pinOe(pinOe),
      .pinIe(pinIe)
   );

   // clock-type outputs that may keep running through software standby
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         {rtcOutOe, rtcOutPin} <= 2'h0;
         {clkOutOe, clkOutPin} <= 2'h0;
      end
      else if (ce)
      begin
         {rtcOutOe, rtcOutPin} <= liveOutNext(pinMode, funcCtrl[BIT_RTC_SEL],
            rtcClkLive, rtcOutOe, rtcOutPin);
         {clkOutOe, clkOutPin} <= liveOutNext(pinMode, funcCtrl[BIT_CLK_SEL],
            clkOutLive, clkOutOe, clkOutPin);
      end
   end

   // debug, mode-strap, analog and USB pins
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         tdoOut <= 1'b0;
         tdoOe <= 1'b1;
         jtagPullUp <= 1'b1;
         bootModePullUp <= 1'b1;
         analogOutValue <= '0;
         analogOutOe <= 1'b0;
         usbDataIe <= 1'b0;
      end
      else if (ce)
      begin
         case (pinMode)
            MODE_RUN:
            begin
               tdoOut <= tdoLive;
               tdoOe <= 1'b1;
               jtagPullUp <= funcCtrl[BIT_PULL_EN];
               bootModePullUp <= funcCtrl[BIT_PULL_EN];
               analogOutValue <= analogData;
               analogOutOe <= funcCtrl[BIT_ANALOG_OE];
               usbDataIe <= funcCtrl[BIT_USB_INPUT];
            end
            MODE_SW_STBY:
            begin
               // converter output stays enabled only while its enable bit is set; the value is always kept
               if (!funcCtrl[BIT_ANALOG_OE])
                  analogOutOe <= 1'b0;
               usbDataIe <= funcCtrl[BIT_USB_INPUT];
            end
            MODE_DEEP_STBY:
               usbDataIe <= usbDataIe | funcCtrl[BIT_USB_DEEP_WAKE];
            MODE_RETAIN:
               usbDataIe <= usbDataIe;
            default:
            begin
               // startup without retention: all float, debug output alive
               tdoOut <= tdoLive;
               tdoOe <= 1'b1;
               jtagPullUp <= 1'b0;
               bootModePullUp <= 1'b0;
               analogOutOe <= 1'b0;
               usbDataIe <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence swStay;
      ce && pinMode == MODE_SW_STBY && next_mode == MODE_SW_STBY;
   endsequence
   sequence deepStay;
      ce && pinMode == MODE_DEEP_STBY && next_mode == MODE_DEEP_STBY;
   endsequence

   a_scan_held_reset: assert property (disable iff (1'b0) srst |=> !scanEnable)
      else $error("scan enabled during reset");
   a_scan_after_release: assert property (ce |=> scanEnable)
      else $error("scan not enabled after reset release");
   a_sw_drive_kept: assert property (ce && pinMode == MODE_SW_STBY |=>
      $stable(pinOut) && $stable(pinOe) && (pinIe & pinOe) == '0)
      else $error("drive changed in software standby");
   a_deep_state_frozen: assert property (deepStay ##1 deepStay |=>
      $stable(pinOut) && $stable(pinOe) && $stable(tdoOut) && $stable(jtagPullUp))
      else $error("pin state moved in deep standby");
   a_retain_until_clear: assert property (ce && pinMode == MODE_RETAIN && ioRetention |=>
      pinMode == MODE_RETAIN && $stable(pinOut) && $stable(pinOe))
      else $error("retained pins released early");
   a_startup_float: assert property (ce && pinMode == MODE_STARTUP |=>
      pinOe == '0 && tdoOe && !analogOutOe)
      else $error("startup pins not floating");
   a_sw_wake_input: assert property (swStay ##1 swStay |=>
      (swWake & ~pinOe & ~pinIe) == '0)
      else $error("standby wake pin input disabled");
   a_deep_wake_input: assert property (deepStay ##1 deepStay |=>
      (dsWake & ~pinIe) == '0)
      else $error("deep wake pin input disabled");
   a_usb_input_standby: assert property (ce && pinMode == MODE_SW_STBY |=>
      usbDataIe == $past(funcCtrl[BIT_USB_INPUT]))
      else $error("usb data input enable wrong in standby");
   a_rtc_out_live: assert property (ce && pinMode == MODE_SW_STBY && funcCtrl[BIT_RTC_SEL]
      |=> rtcOutOe && rtcOutPin == $past(rtcClkLive))
      else $error("rtc clock output stopped in standby");
   a_clk_out_live: assert property (ce && pinMode == MODE_SW_STBY && funcCtrl[BIT_CLK_SEL]
      |=> clkOutOe && clkOutPin == $past(clkOutLive))
      else $error("clock output stopped in standby");
   a_analog_kept: assert property (ce && pinMode == MODE_SW_STBY && funcCtrl[BIT_ANALOG_OE]
      |=> analogOutOe && $stable(analogOutValue))
      else $error("analog output lost in standby");
   a_reset_pin_state: assert property (disable iff (1'b0) srst |=>
      bootModePullUp && jtagPullUp && tdoOe && pinOe == '0 && !rtcOutOe)
      else $error("reset pin state wrong");
endmodule : low_power_pin_state_control

/* verif/board_pins.sv */
/*
 Board wiring seen by the general pins: each pad carries a weak pull-down.
 Assumes pinOut and pinOe come straight from the controller, one bit per pad.
*/
`timescale 1ns/1ps
module board_pins #(
   parameter int NUM_PINS = 16
) (
   input wire logic [NUM_PINS-1:0] pinOut,
   input wire logic [NUM_PINS-1:0] pinOe,
   output logic [NUM_PINS-1:0] padLevel
);
   // released pads fall to the pull-down, never to the last driven value
   always_comb
   begin
      padLevel = pinOut & pinOe;
   end
endmodule : board_pins

/* verif/tb_low_power_pin_state_control.sv */
/*
 Self-checking bench for the pin-state controller: register access over
 AXI4-Lite, then run, standby, deep standby, retention and startup in turn.
 Assumes the default pin count and a single 100 MHz clock.
*/
`timescale 1ns/1ps
module tb_low_power_pin_state_control;
   import pin_state_pkg::*;
   localparam int N = 16;
   logic clk, srst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, swStandbyReq, deepStandbyReq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [N-1:0] liveOut, liveOe, pinOut, pinOe, pinIe, padLevel;
   logic tdoLive, tdoOut, tdoOe, jtagPullUp, bootModePullUp, scanEnable;
   logic rtcClkLive, rtcOutPin, rtcOutOe, clkOutLive, clkOutPin, clkOutOe;
   logic [11:0] analogOutValue;
   logic analogOutOe, usbDataIe;
   pin_mode_e pinMode;
   int numErrors = 0;
   int samplesChecked = 0;
   int cycles = 0;

   low_power_pin_state_control #(.NUM_PINS(N), .ANALOG_BITS(12)) dut (.clk(clk), .srst(srst),
      .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .swStandbyReq(swStandbyReq),
      .deepStandbyReq(deepStandbyReq), .liveOut(liveOut), .liveOe(liveOe), .pinOut(pinOut),
      .pinOe(pinOe), .pinIe(pinIe), .tdoLive(tdoLive), .tdoOut(tdoOut), .tdoOe(tdoOe),
      .jtagPullUp(jtagPullUp), .bootModePullUp(bootModePullUp), .scanEnable(scanEnable),
      .rtcClkLive(rtcClkLive), .rtcOutPin(rtcOutPin), .rtcOutOe(rtcOutOe),
      .clkOutLive(clkOutLive), .clkOutPin(clkOutPin), .clkOutOe(clkOutOe),
      .analogOutValue(analogOutValue), .analogOutOe(analogOutOe), .usbDataIe(usbDataIe),
      .pinMode(pinMode));

   board_pins #(.NUM_PINS(N)) board (.pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));

   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic stopTest;
      $display("checks %0d mismatches %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stopTest

   // a run far beyond the expected hundred or so cycles means a hung handshake
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         numErrors++;
         stopTest();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(awDone && wDone))
      begin
         @(posedge clk);
         if (awvalid && awready)
         begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge clk); while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk); while (rvalid !== 1'b1);
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask : rd

   // pins settle one edge after the mode shows
   task automatic waitMode(input pin_mode_e m);
      while (pinMode !== m)
         @(posedge clk);
      @(posedge clk);
      #1;
   endtask : waitMode

   initial
   begin
      srst = 1'b1;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      {swStandbyReq, deepStandbyReq} = '0;
      liveOut = 16'hA5C3;
      liveOe = 16'h0FF0;
      {tdoLive, rtcClkLive, clkOutLive} = 3'h7;
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, scanEnable}, 32'h0);
      chk({29'h0, tdoOe, jtagPullUp, bootModePullUp}, 32'h7);
      chk({16'h0, pinOe}, 32'h0);
      srst <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      chk({31'h0, scanEnable}, 32'h1);
      // register map, reset value and refusals
      rd(OFS_FUNC_CTRL, 32'h20, RESP_OKAY);
      rd(8'h18, 32'h0, RESP_SLVERR);
      wr(8'h18, 32'hFFFF, RESP_SLVERR);
      wr(OFS_FUNC_CTRL, 32'h2F, RESP_OKAY);
      wr(OFS_ANALOG, 32'hABC, RESP_OKAY);
      wr(OFS_SW_WAKE, 32'h3C3C, RESP_OKAY);
      wr(OFS_DEEP_WAKE, 32'h0030, RESP_OKAY);
      wr(OFS_DEEP_CTRL, 32'h1, RESP_OKAY);
      rd(OFS_FUNC_CTRL, 32'h2F, RESP_OKAY);
      // software standby: drivers freeze, live inputs then change under them
      swStandbyReq <= 1'b1;
      waitMode(MODE_SW_STBY);
      liveOut <= 16'h5A3C;
      // live clocks move so a frozen clock pin would show
      {rtcClkLive, clkOutLive} <= 2'h0;
      liveOe <= 16'hFFFF;
      repeat (2) @(posedge clk);
      #1;
      chk({16'h0, pinOut & 16'h0FF0}, 32'h05C0);
      chk({16'h0, pinOe}, 32'h0FF0);
      chk({16'h0, padLevel}, 32'h05C0);
      chk({16'h0, pinIe}, 32'h300C);
      chk({30'h0, rtcOutOe, rtcOutPin}, 32'h2);
      chk({30'h0, clkOutOe, clkOutPin}, 32'h2);
      chk({19'h0, analogOutOe, analogOutValue}, 32'h1ABC);
      chk({31'h0, usbDataIe}, 32'h1);
      rd(OFS_STATUS, 32'h11, RESP_OKAY);
      swStandbyReq <= 1'b0;
      waitMode(MODE_RUN);
      liveOut <= 16'hA5C3;
      liveOe <= 16'h0FF0;
      // USB data lines as outputs lose the input path in standby
      wr(OFS_FUNC_CTRL, 32'h27, RESP_OKAY);
      swStandbyReq <= 1'b1;
      waitMode(MODE_SW_STBY);
      chk({31'h0, usbDataIe}, 32'h0);
      swStandbyReq <= 1'b0;
      waitMode(MODE_RUN);
      // deep standby with retention set
      deepStandbyReq <= 1'b1;
      waitMode(MODE_DEEP_STBY);
      liveOut <= 16'h1234;
      liveOe <= 16'hFFFF;
      repeat (2) @(posedge clk);
      #1;
      chk({pinOe, pinOut}, 32'h0FF0A5C3);
      chk({16'h0, pinIe & 16'h0030}, 32'h30);
      deepStandbyReq <= 1'b0;
      waitMode(MODE_RETAIN);
      chk({pinOe, pinOut}, 32'h0FF0A5C3);
      rd(OFS_STATUS, 32'h13, RESP_OKAY);
      chk({pinOe, pinOut}, 32'h0FF0A5C3);
      wr(OFS_DEEP_CTRL, 32'h0, RESP_OKAY);
      waitMode(MODE_RUN);
      @(posedge clk);
      #1;
      chk({pinOe, pinOut}, 32'hFFFF1234);
      // deep standby without retention returns through startup
      deepStandbyReq <= 1'b1;
      waitMode(MODE_DEEP_STBY);
      deepStandbyReq <= 1'b0;
      // debug data moves so a held output would show in startup
      tdoLive <= 1'b0;
      waitMode(MODE_STARTUP);
      chk({16'h0, pinOe}, 32'h0);
      chk({30'h0, tdoOe, tdoOut}, 32'h2);
      rd(OFS_STATUS, 32'h14, RESP_OKAY);
      wr(OFS_DEEP_CTRL, 32'h0, RESP_OKAY);
      waitMode(MODE_RUN);
      // clock enable low freezes the pins against live changes
      ce <= 1'b0;
      liveOut <= 16'h00FF;
      repeat (2) @(posedge clk);
      #1;
      chk({pinOe, pinOut}, 32'hFFFF1234);
      ce <= 1'b1;
      stopTest();
   end
endmodule : tb_low_power_pin_state_control
